// ### design/ppt_grp_out.sv
// holds the four output bits of one group
// assumes trigger and software write come from the same clock domain
`timescale 1ns/1ps
module ppt_grp_out (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  hw_standby,
  // group carrier
  ppt_grp_if.grp_mp  g
);
  import ppt_pkg::*;

  logic [PPT_GRP_W-1:0] base;   // value before the trigger is applied

  // ----------------------------------------------------------------
  // output bits
  // ----------------------------------------------------------------
  // software write first, then trigger overrides enabled bits
  always_comb begin
    base = g.wr ? g.wr_data : g.port;
  end

  // a trigger beats a software write on enabled bits in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      g.port <= PPT_PORT_RST;
    end else if (hw_standby) begin
      g.port <= PPT_PORT_RST;
    end else if (g.trig) begin
      g.port <= (g.en & g.nxt) | (~g.en & base);
    end else begin
      g.port <= base;
    end
  end
endmodule

// ### design/ppt_top.sv
// pulse output unit: trigger select register, next data, enables, outputs
// assumes a 100 MHz clock, synchronous compare strobes and an avalon-mm master
`timescale 1ns/1ps
module ppt_top (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // power states
  input  wire logic                          hw_standby,
  input  wire logic                          sw_standby,
  // avalon-mm slave
  input  wire logic [ppt_pkg::PPT_AW-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [ppt_pkg::PPT_DW-1:0]    avs_writedata,
  input  wire logic [ppt_pkg::PPT_BW-1:0]    avs_byteenable,
  output logic      [ppt_pkg::PPT_DW-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  // timer compare match a strobes, one per channel
  input  wire logic [ppt_pkg::PPT_CH_N-1:0]  cm_a,
  // pulse outputs
  output logic      [ppt_pkg::PPT_GRP_N*ppt_pkg::PPT_GRP_W-1:0] port_out
);
  import ppt_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ppt_bus_st_t             bus_st_q;        // bus handshake state
  logic                    wait_q;          // registered waitrequest
  logic [PPT_DW-1:0]       rdata_q;         // registered read data
  logic [PPT_REG_W-1:0]    trig_sel_q;      // pulse_trigger_select
  logic [PPT_REG_W-1:0]    nxt_lo_q;        // next_pattern_low
  logic [PPT_REG_W-1:0]    nxt_hi_q;        // next_pattern_high
  logic [PPT_REG_W-1:0]    en_lo_q;         // next_enable_low
  logic [PPT_REG_W-1:0]    en_hi_q;         // next_enable_high
  logic                    req;             // any request present
  logic                    acc_wr;          // write takes effect now
  logic                    lane0;           // low byte lane enabled
  logic [PPT_REG_W-1:0]    wbyte;           // low byte of write data
  logic [PPT_DW-1:0]       rdata_d;         // read mux result
  logic [PPT_REG_W-1:0]    port_lo;         // groups 1 and 0 outputs
  logic [PPT_REG_W-1:0]    port_hi;         // groups 3 and 2 outputs
  logic [PPT_GRP_N*PPT_SEL_W-1:0] sel_all;  // per-group select fields
  logic [PPT_GRP_N*PPT_GRP_W-1:0] nxt_all;  // next data, all groups
  logic [PPT_GRP_N*PPT_GRP_W-1:0] en_all;   // enables, all groups
  logic [PPT_GRP_N*PPT_GRP_W-1:0] port_all; // outputs, all groups
  logic [PPT_GRP_N-1:0]    port_wr;         // software write per group
  logic [PPT_GRP_N*PPT_GRP_W-1:0] port_wd;  // software data per group

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // registers are eight bits wide and sit in byte lane 0 only
  always_comb begin
    req    = avs_read | avs_write;
    acc_wr = avs_write & (bus_st_q == PPT_BUS_ANS);
    lane0  = avs_byteenable[0];
    wbyte  = avs_writedata[PPT_REG_W-1:0];
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait cycle per access: the request is seen with waitrequest
  // high, the next cycle drops it and the master completes there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_st_q <= PPT_BUS_IDLE;
      wait_q   <= 1'b1;
    end else begin
      unique case (bus_st_q)
        PPT_BUS_IDLE: begin
          if (req) begin
            bus_st_q <= PPT_BUS_ANS;
            wait_q   <= 1'b0;
          end
        end
        PPT_BUS_ANS: begin
          // master completes at this edge, so drop back
          bus_st_q <= PPT_BUS_IDLE;
          wait_q   <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // unmapped offsets read as zero; upper bits always zero
  always_comb begin
    rdata_d = PPT_RD_ZERO;
    unique case (avs_address)
      PPT_OFF_TRIG_SEL: rdata_d[PPT_REG_W-1:0] = trig_sel_q;
      PPT_OFF_NXT_LO:   rdata_d[PPT_REG_W-1:0] = nxt_lo_q;
      PPT_OFF_NXT_HI:   rdata_d[PPT_REG_W-1:0] = nxt_hi_q;
      PPT_OFF_EN_LO:    rdata_d[PPT_REG_W-1:0] = en_lo_q;
      PPT_OFF_EN_HI:    rdata_d[PPT_REG_W-1:0] = en_hi_q;
      PPT_OFF_PORT_LO:  rdata_d[PPT_REG_W-1:0] = port_lo;
      PPT_OFF_PORT_HI:  rdata_d[PPT_REG_W-1:0] = port_hi;
      default:          rdata_d = PPT_RD_ZERO;
    endcase
  end

  // captured when the request is first seen, stands through the answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= PPT_RD_ZERO;
    end else if (bus_st_q == PPT_BUS_IDLE && avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // trigger select register
  // ----------------------------------------------------------------
  // no sw_standby term here on purpose: the register simply holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sel_q <= PPT_TRIG_SEL_RST;
    end else if (hw_standby) begin
      trig_sel_q <= PPT_TRIG_SEL_RST;
    end else if (acc_wr && lane0 && avs_address == PPT_OFF_TRIG_SEL) begin
      trig_sel_q <= wbyte;
    end
  end

  // sw_standby deliberately steers nothing: every register keeps state

  // ----------------------------------------------------------------
  // next data registers
  // ----------------------------------------------------------------
  // software refreshes these ahead of the next compare match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nxt_lo_q <= PPT_NXT_RST;
      nxt_hi_q <= PPT_NXT_RST;
    end else if (hw_standby) begin
      nxt_lo_q <= PPT_NXT_RST;
      nxt_hi_q <= PPT_NXT_RST;
    end else if (acc_wr && lane0) begin
      if (avs_address == PPT_OFF_NXT_LO) begin
        nxt_lo_q <= wbyte;
      end
      if (avs_address == PPT_OFF_NXT_HI) begin
        nxt_hi_q <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // next enable registers
  // ----------------------------------------------------------------
  // a clear bit shields its output from every trigger
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_lo_q <= PPT_EN_RST;
      en_hi_q <= PPT_EN_RST;
    end else if (hw_standby) begin
      en_lo_q <= PPT_EN_RST;
      en_hi_q <= PPT_EN_RST;
    end else if (acc_wr && lane0) begin
      if (avs_address == PPT_OFF_EN_LO) begin
        en_lo_q <= wbyte;
      end
      if (avs_address == PPT_OFF_EN_HI) begin
        en_hi_q <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // field split per group
  // ----------------------------------------------------------------
  // each select field goes to its own group; lsb positions named apart
  always_comb begin
    sel_all = '0;
    sel_all[PPT_SEL_W*3 +: PPT_SEL_W] = trig_sel_q[PPT_GRP3_SEL_LSB +: PPT_SEL_W];
    sel_all[PPT_SEL_W*2 +: PPT_SEL_W] = trig_sel_q[PPT_GRP2_SEL_LSB +: PPT_SEL_W];
    sel_all[PPT_SEL_W*1 +: PPT_SEL_W] = trig_sel_q[PPT_GRP1_SEL_LSB +: PPT_SEL_W];
    sel_all[PPT_SEL_W*0 +: PPT_SEL_W] = trig_sel_q[PPT_GRP0_SEL_LSB +: PPT_SEL_W];
  end

  // low registers feed groups 0 and 1, high registers groups 2 and 3
  always_comb begin
    nxt_all = {nxt_hi_q, nxt_lo_q};
    en_all  = {en_hi_q, en_lo_q};
    port_wd = {wbyte, wbyte};
    port_wr[0] = acc_wr && lane0 && avs_address == PPT_OFF_PORT_LO;
    port_wr[1] = port_wr[0];
    port_wr[2] = acc_wr && lane0 && avs_address == PPT_OFF_PORT_HI;
    port_wr[3] = port_wr[2];
  end

  // ----------------------------------------------------------------
  // per-group trigger and output logic
  // ----------------------------------------------------------------
  // the compare strobe acts in the cycle it arrives; no extra stage
  for (genvar gi = 0; gi < PPT_GRP_N; gi++) begin : g_grp
    ppt_grp_if gif ();

    assign gif.sel     = ppt_chan_t'(sel_all[gi*PPT_SEL_W +: PPT_SEL_W]);
    assign gif.cm_a    = cm_a;
    assign gif.nxt     = nxt_all[gi*PPT_GRP_W +: PPT_GRP_W];
    assign gif.en      = en_all[gi*PPT_GRP_W +: PPT_GRP_W];
    assign gif.wr      = port_wr[gi];
    assign gif.wr_data = port_wd[gi*PPT_GRP_W +: PPT_GRP_W];
    assign port_all[gi*PPT_GRP_W +: PPT_GRP_W] = gif.port;

    // strobe chosen by the group's field
    ppt_trig_mux u_mux (
      .g (gif.mux_mp)
    );

    // output bits, updated on the chosen strobe
    ppt_grp_out u_out (
      .clk        (clk),
      .rst_n      (rst_n),
      .hw_standby (hw_standby),
      .g          (gif.grp_mp)
    );
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output below is a flip-flop, either here or in the group
  always_comb begin
    port_lo = port_all[PPT_REG_W-1:0];
    port_hi = port_all[2*PPT_REG_W-1:PPT_REG_W];
  end

  assign port_out        = port_all;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule

// ### design/ppt_trig_mux.sv
// picks one compare match strobe for one output group
// assumes strobes are one-cycle pulses synchronous to the clock
`timescale 1ns/1ps
module ppt_trig_mux (
  // group carrier
  ppt_grp_if.mux_mp g
);
  import ppt_pkg::*;

  // ----------------------------------------------------------------
  // channel decode
  // ----------------------------------------------------------------
  // only compare match a reaches here; b is never wired in
  always_comb begin
    unique case (g.sel)
      PPT_CH0: g.trig = g.cm_a[0];
      PPT_CH1: g.trig = g.cm_a[1];
      PPT_CH2: g.trig = g.cm_a[2];
      PPT_CH3: g.trig = g.cm_a[3];
    endcase
  end
endmodule

// ### pkg/ppt_grp_if.sv
// carrier between the top and the per-group trigger and output logic
// assumes all signals are synchronous to the top clock
`timescale 1ns/1ps
interface ppt_grp_if;
  import ppt_pkg::*;
  ppt_chan_t              sel;      // chosen timer channel
  logic [PPT_CH_N-1:0]    cm_a;     // compare match a strobes
  logic                   trig;     // selected strobe
  logic [PPT_GRP_W-1:0]   nxt;      // next pattern bits
  logic [PPT_GRP_W-1:0]   en;       // next enable bits
  logic                   wr;       // software port write
  logic [PPT_GRP_W-1:0]   wr_data;  // software port data
  logic [PPT_GRP_W-1:0]   port;     // output bits

  modport mux_mp (input sel, input cm_a, output trig);
  modport grp_mp (input trig, input nxt, input en, input wr, input wr_data, output port);
endinterface

// ### pkg/ppt_pkg.sv
// constants, field layout and types for the pulse output trigger select block
// assumes one 100 MHz clock and a 32-bit avalon-mm slave port with byte addresses
//
// What this block does
// - eight-bit read/write register, four two-bit trigger fields
// - reset and hardware standby load all ones
// - software standby leaves the register untouched
// - bits 7:6 pick group 3 timer channel
// - bits 5:4 pick group 2 timer channel
// - bits 3:2 pick group 1 timer channel
// - bits 1:0 pick group 0 timer channel
// - on trigger, enabled bits take next data
// - group triggers come only from compare match a, never b
package ppt_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int PPT_AW = 5;                      // byte address width
  localparam int PPT_DW = 32;                     // bus data width
  localparam int PPT_BW = 4;                      // byte enables

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [PPT_AW-1:0] PPT_OFF_TRIG_SEL  = 5'h00; // pulse_trigger_select
  localparam logic [PPT_AW-1:0] PPT_OFF_NXT_LO    = 5'h04; // next_pattern_low
  localparam logic [PPT_AW-1:0] PPT_OFF_NXT_HI    = 5'h08; // next_pattern_high
  localparam logic [PPT_AW-1:0] PPT_OFF_EN_LO     = 5'h0c; // next_enable_low
  localparam logic [PPT_AW-1:0] PPT_OFF_EN_HI     = 5'h10; // next_enable_high
  localparam logic [PPT_AW-1:0] PPT_OFF_PORT_LO   = 5'h14; // port_low_out
  localparam logic [PPT_AW-1:0] PPT_OFF_PORT_HI   = 5'h18; // port_high_out

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int PPT_GRP_N = 4;                   // output groups
  localparam int PPT_GRP_W = 4;                   // outputs per group
  localparam int PPT_SEL_W = 2;                   // select field width
  localparam int PPT_CH_N  = 4;                   // timer channels
  localparam int PPT_REG_W = 8;                   // register width
  localparam int PPT_GRP3_SEL_LSB = 6;            // bits 7:6
  localparam int PPT_GRP2_SEL_LSB = 4;            // bits 5:4
  localparam int PPT_GRP1_SEL_LSB = 2;            // bits 3:2
  localparam int PPT_GRP0_SEL_LSB = 0;            // bits 1:0
  localparam logic [PPT_REG_W-1:0] PPT_TRIG_SEL_RST = 8'hff; // every group on channel 3
  localparam logic [PPT_REG_W-1:0] PPT_NXT_RST      = 8'h00;
  localparam logic [PPT_REG_W-1:0] PPT_EN_RST       = 8'h00;
  localparam logic [PPT_GRP_W-1:0] PPT_PORT_RST     = 4'h0;
  localparam logic [PPT_DW-1:0]    PPT_RD_ZERO      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPT_CH0 = 2'b00,
    PPT_CH1 = 2'b01,
    PPT_CH2 = 2'b10,
    PPT_CH3 = 2'b11
  } ppt_chan_t;

  typedef enum logic {
    PPT_BUS_IDLE = 1'b0,                          // waiting for a request
    PPT_BUS_ANS  = 1'b1                           // answer cycle, waitrequest low
  } ppt_bus_st_t;

endpackage

// ### tb/ppt_cm_model.sv
// compare match a strobe source for four timer channels
// assumes the bench arms channels right after a clock edge
`timescale 1ns/1ps
module ppt_cm_model (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // arming from the bench
  input wire logic [3:0]  fire,
  input wire logic [7:0]  dly,
  // strobes
  output logic     [3:0]  cm_a
);
  logic [3:0] arm_q;     // channel counting toward its match
  logic [7:0] cnt_q [4]; // cycles left; zero gives a prompt match
  // each armed channel counts down and strobes exactly once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 4'h0;
      for (int c = 0; c < 4; c++) cnt_q[c] <= 8'h00;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (fire[c]) begin
          arm_q[c] <= 1'b1;
          cnt_q[c] <= dly;
        end else if (cm_a[c]) begin
          arm_q[c] <= 1'b0;  // one pulse per arming
        end else if (arm_q[c]) begin
          cnt_q[c] <= cnt_q[c] - 8'h01;
        end
      end
    end
  end
  // only compare match a strobes exist; idle low between matches
  always_comb begin
    for (int c = 0; c < 4; c++) cm_a[c] = arm_q[c] && (cnt_q[c] == 8'h00);
  end
endmodule

// ### tb/ppt_monitor.sv
// checker for ppt_top, bound to its ports
// assumes one clock and writes landing at the edge where waitrequest is low
`timescale 1ns/1ps
module ppt_monitor (
  // clock, reset, power
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        hw_standby,
  // avalon-mm slave
  input wire logic [ppt_pkg::PPT_AW-1:0]  avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [ppt_pkg::PPT_DW-1:0]  avs_writedata,
  input wire logic [ppt_pkg::PPT_BW-1:0]  avs_byteenable,
  input wire logic [ppt_pkg::PPT_DW-1:0]  avs_readdata,
  input wire logic                        avs_waitrequest,
  // strobes and outputs
  input wire logic [ppt_pkg::PPT_CH_N-1:0] cm_a,
  input wire logic [ppt_pkg::PPT_GRP_N*ppt_pkg::PPT_GRP_W-1:0] port_out
);
  import ppt_pkg::*;
  // --------
  // shadow copies
  // --------
  logic [7:0]  sel_q;    // trigger select copy
  logic [15:0] nxt_q;    // next data copy
  logic [15:0] en_q;     // enable copy
  logic [15:0] hit;      // bits whose chosen strobe fired and are enabled
  logic [15:0] exp_port; // port value due after this edge
  logic        wr_ok;    // write lands at this edge
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  // copies follow the bus so reads and triggers can be predicted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= PPT_TRIG_SEL_RST;
      nxt_q <= 16'h0;
      en_q  <= 16'h0;
    end else if (hw_standby) begin
      sel_q <= PPT_TRIG_SEL_RST;
      nxt_q <= 16'h0;
      en_q  <= 16'h0;
    end else if (wr_ok) begin
      case (avs_address)
        PPT_OFF_TRIG_SEL: sel_q <= avs_writedata[7:0];
        PPT_OFF_NXT_LO:   nxt_q[7:0] <= avs_writedata[7:0];
        PPT_OFF_NXT_HI:   nxt_q[15:8] <= avs_writedata[7:0];
        PPT_OFF_EN_LO:    en_q[7:0] <= avs_writedata[7:0];
        PPT_OFF_EN_HI:    en_q[15:8] <= avs_writedata[7:0];
        default: ;        // port registers are not predicted here
      endcase
    end
  end
  // group g listens only to the channel named in its field
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      hit[4*g+:4] = {4{cm_a[sel_q[2*g+:2]]}} & en_q[4*g+:4];
    end
  end
  assign exp_port = (port_out & ~hit) | (nxt_q & hit);
  // --------
  // assertions
  // --------
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_ans_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_ans_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer given without a request");
  chk_sel_read: assert property (avs_read && !avs_waitrequest && avs_address == PPT_OFF_TRIG_SEL
      |-> avs_readdata == {24'h0, sel_q}) else $error("trigger select read back wrong");
  chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_read_gap: assert property (avs_read && !avs_waitrequest && avs_address > PPT_OFF_PORT_HI
      |-> avs_readdata == PPT_RD_ZERO) else $error("unmapped read not zero");
  chk_standby_clear: assert property (hw_standby |=> port_out == 16'h0)
    else $error("hardware standby left outputs set");
  chk_trig_update: assert property (!(avs_write && !avs_waitrequest) && !hw_standby
      |=> port_out == $past(exp_port)) else $error("outputs differ from selected trigger update");
  cover property (hit != 16'h0);
  cover property (wr_ok && avs_address == PPT_OFF_TRIG_SEL);
  cover property (hw_standby);
endmodule
bind ppt_top ppt_monitor mon_u (.clk(clk), .rst_n(rst_n), .hw_standby(hw_standby), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cm_a(cm_a), .port_out(port_out));

// ### tb/pulse_output_trigger_select_test.sv
// self-checking bench for the pulse output trigger select block
// assumes ppt_top with its bound checker and the strobe model
`timescale 1ns/1ps
module pulse_output_trigger_select_test;
  import ppt_pkg::*;
  // --------
  // signals and expectations
  // --------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hw_standby = 1'b0;
  logic        sw_standby = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  cm_a;
  logic [15:0] port_out;
  logic [3:0]  fire = 4'h0;
  logic [7:0]  dly = 8'h00;
  logic        cm_seen = 1'b0;      // a strobe was seen one edge ago
  logic [31:0] seed = 32'h21e9e9c2;
  logic [7:0]  sel_e = 8'hff;       // expected select
  logic [15:0] nxt_e = 16'h0;
  logic [15:0] en_e = 16'h0;
  logic [15:0] port_e = 16'h0;
  logic [31:0] rd_q[$];             // read notes
  logic [15:0] pt_q[$];             // port notes
  int          fails = 0;
  int          checked = 0;
  always #5 clk = ~clk;
  ppt_top dut_u (.clk(clk), .rst_n(rst_n), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cm_a(cm_a), .port_out(port_out));
  ppt_cm_model cm_u (.clk(clk), .rst_n(rst_n), .fire(fire), .dly(dly), .cm_a(cm_a));
  // --------
  // helpers
  // --------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic judge(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] g);
    logic [31:0] e;
    e = 32'hx;   // empty queue must mismatch
    if (rd_q.size() > 0) e = rd_q.pop_front();
    judge(e, g);
  endtask
  task automatic cmp_port(input logic [15:0] g);
    logic [15:0] e;
    e = 16'hx;
    if (pt_q.size() > 0) e = pt_q.pop_front();
    judge({16'h0, e}, {16'h0, g});
  endtask
  // request held until waitrequest is sampled low; no release here,
  // so back-to-back calls never drive a signal twice in one step
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    seed = lfsr(seed);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {seed[31:8], d};  // unused lanes carry noise
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      summarize();
    end
  endtask
  task automatic rd8(input logic [4:0] a, input logic [7:0] e);
    rd_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00, 4'hf);
  endtask
  task automatic idle();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // arm channels in m, note the port value due one edge after the strobe
  task automatic trig(input logic [3:0] m);
    logic [15:0] h;
    int n;
    for (int g = 0; g < 4; g++) h[4*g+:4] = {4{m[sel_e[2*g+:2]]}} & en_e[4*g+:4];
    port_e = (port_e & ~h) | (nxt_e & h);
    pt_q.push_back(port_e);
    seed = lfsr(seed);
    fire <= m;
    dly <= {5'h0, seed[2:0]};  // prompt and slow matches
    @(posedge clk);
    fire <= 4'h0;
    n = 0;
    while (cm_a === 4'h0 && n < 32) begin
      @(posedge clk);
      n++;
    end
    if (n >= 32) begin
      fails++;
      summarize();
    end
    @(posedge clk);
  endtask
  // watcher: read data at the answer edge, port one edge after a strobe
  always @(posedge clk) begin
    if (cm_seen) cmp_port(port_out);
    cm_seen = (cm_a !== 4'h0);
    if (avs_read && !avs_waitrequest) cmp_rd(avs_readdata);
  end
  // --------
  // main sequence
  // --------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd8(PPT_OFF_TRIG_SEL, 8'hff);
    rd8(5'h1c, 8'h00);            // unmapped place reads zero
    bus(1'b1, 5'h1c, 8'h5a, 4'hf);
    // software port writes land and read back; later triggers start from here
    bus(1'b1, PPT_OFF_PORT_LO, 8'h3c, 4'hf);
    bus(1'b1, PPT_OFF_PORT_HI, 8'hc3, 4'hf);
    port_e = 16'hc33c;
    rd8(PPT_OFF_PORT_HI, 8'hc3);
    rd8(PPT_OFF_PORT_LO, 8'h3c);
    // every field takes every code; every channel fires once per layout
    for (int k = 0; k < 4; k++) begin
      for (int g = 0; g < 4; g++) sel_e[2*g+:2] = 2'((g + k) % 4);
      bus(1'b1, PPT_OFF_TRIG_SEL, sel_e, 4'hf);
      rd8(PPT_OFF_TRIG_SEL, sel_e);
      for (int c = 0; c < 4; c++) begin
        seed = lfsr(seed);
        nxt_e = seed[15:0];
        en_e = seed[31:16];
        bus(1'b1, PPT_OFF_NXT_LO, nxt_e[7:0], 4'hf);
        bus(1'b1, PPT_OFF_NXT_HI, nxt_e[15:8], 4'hf);
        bus(1'b1, PPT_OFF_EN_LO, en_e[7:0], 4'hf);
        bus(1'b1, PPT_OFF_EN_HI, en_e[15:8], 4'hf);
        idle();
        trig(4'(1 << c));
      end
    end
    trig(4'hf);
    // next data, enables and the updated outputs read back live
    rd8(PPT_OFF_NXT_LO, nxt_e[7:0]);
    rd8(PPT_OFF_EN_HI, en_e[15:8]);
    rd8(PPT_OFF_PORT_LO, port_e[7:0]);
    rd8(PPT_OFF_PORT_HI, port_e[15:8]);
    // a write without lane 0 must not touch the select
    bus(1'b1, PPT_OFF_TRIG_SEL, 8'h00, 4'he);
    rd8(PPT_OFF_TRIG_SEL, sel_e);
    idle();
    sw_standby <= 1'b1;
    repeat (4) @(posedge clk);
    rd8(PPT_OFF_TRIG_SEL, sel_e);
    idle();
    trig(4'(1 << sel_e[1:0]));
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    @(posedge clk);
    hw_standby <= 1'b0;
    sel_e = 8'hff;
    nxt_e = 16'h0;
    en_e = 16'h0;
    port_e = 16'h0;
    rd8(PPT_OFF_TRIG_SEL, 8'hff);
    rd8(PPT_OFF_EN_LO, 8'h00);
    rd8(PPT_OFF_PORT_HI, 8'h00);
    idle();
    trig(4'h8);
    // let the watcher take the last note before judging; leftovers count
    @(posedge clk);
    if (rd_q.size() != 0 || pt_q.size() != 0) fails++;
    summarize();
  end
endmodule
